// [include/cid_pkg.sv]
// package of opcode fields and decoded operation codes for the compressed decoder
package cid_pkg;

   // ****************************************
   // field positions
   // ****************************************
   localparam int MAJOR_HI = 15;
   localparam int MAJOR_LO = 11;
   localparam int MODE_BIT = 10;      // bit 26 of the 32-bit jump word
   localparam int RRIA_BIT = 4;
   localparam int SAVE_RESTORE_CLASS_BIT = 7;
   localparam int SUB_HI = 7;
   localparam int SUB_LO = 5;
   localparam int I8_HI = 10;
   localparam int I8_LO = 8;
   localparam int RR_HI = 4;
   localparam int RR_LO = 0;
   localparam int F2_HI = 1;
   localparam int F2_LO = 0;

   // ****************************************
   // major opcodes
   // ****************************************
   localparam logic [4:0] MJ_STACK_ADD = 5'h00;
   localparam logic [4:0] MJ_PC_ADD = 5'h01;
   localparam logic [4:0] MJ_BRANCH = 5'h02;
   localparam logic [4:0] MJ_JUMP_LINK = 5'h03;
   localparam logic [4:0] MJ_BEQZ = 5'h04;
   localparam logic [4:0] MJ_BNEZ = 5'h05;
   localparam logic [4:0] MJ_SHIFT = 5'h06;
   localparam logic [4:0] MJ_RRIA = 5'h08;
   localparam logic [4:0] MJ_SHORT_ADD = 5'h09;
   localparam logic [4:0] MJ_SLTI = 5'h0A;
   localparam logic [4:0] MJ_SLTIU = 5'h0B;
   localparam logic [4:0] MJ_IMM8 = 5'h0C;
   localparam logic [4:0] MJ_LI = 5'h0D;
   localparam logic [4:0] MJ_CMPI = 5'h0E;
   localparam logic [4:0] MJ_LB = 5'h10;
   localparam logic [4:0] MJ_LH = 5'h11;
   localparam logic [4:0] MJ_STACK_LW = 5'h12;
   localparam logic [4:0] MJ_LW = 5'h13;
   localparam logic [4:0] MJ_LBU = 5'h14;
   localparam logic [4:0] MJ_LHU = 5'h15;
   localparam logic [4:0] MJ_PC_LW = 5'h16;
   localparam logic [4:0] MJ_SB = 5'h18;
   localparam logic [4:0] MJ_SH = 5'h19;
   localparam logic [4:0] MJ_STACK_SW = 5'h1A;
   localparam logic [4:0] MJ_SW = 5'h1B;
   localparam logic [4:0] MJ_THREE_REG = 5'h1C;
   localparam logic [4:0] MJ_TWO_REG = 5'h1D;
   localparam logic [4:0] MJ_EXTEND = 5'h1E;

   // ****************************************
   // two-register function codes used by name
   // ****************************************
   localparam logic [4:0] RR_JREG = 5'h00;
   localparam logic [4:0] RR_CONVERT = 5'h11;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic RST_VALID = 1'b0;

   // decoded operation
   typedef enum logic [6:0] {
      OP_NONE, OP_STACK_ADD_IMM, OP_PC_ADD_IMM, OP_SHORT_ADD_IMM, OP_ADD_IMM3,
      OP_BRANCH, OP_BEQZ, OP_BNEZ, OP_BRANCH_T_ZERO, OP_BRANCH_T_NONZERO,
      OP_JUMP_LINK, OP_JUMP_LINK_EXCHANGE,
      OP_SLL, OP_SRL, OP_SRA, OP_SLTI, OP_SLTIU, OP_LI, OP_CMPI,
      OP_LB, OP_LH, OP_LW, OP_LBU, OP_LHU, OP_SB, OP_SH, OP_SW,
      OP_STACK_LOAD_WORD, OP_PC_LOAD_WORD, OP_STACK_STORE_WORD,
      OP_STORE_RETURN_ADDR_STACK, OP_ADJUST_STACK_PTR,
      OP_SAVE, OP_RESTORE, OP_MOVE_INTO_FULL_REG, OP_MOVE_FROM_FULL_REG,
      OP_ADDU, OP_SUBU, OP_JUMP_REG, OP_JUMP_REG_RA, OP_JUMP_LINK_REG,
      OP_COMPACT_JUMP_REG, OP_COMPACT_JUMP_REG_RA, OP_COMPACT_JUMP_LINK_REG,
      OP_DEBUG_BREAKPOINT, OP_SLT, OP_SLTU, OP_SLLV, OP_BREAK, OP_SRLV, OP_SRAV,
      OP_CMP, OP_NEG, OP_AND, OP_OR, OP_XOR, OP_NOT,
      OP_MFHI, OP_MFLO, OP_MULT, OP_MULTU, OP_DIV, OP_DIVU,
      OP_ZERO_EXTEND_BYTE, OP_ZERO_EXTEND_HALF, OP_SIGN_EXTEND_BYTE, OP_SIGN_EXTEND_HALF,
      OP_EXTEND
   } cid_op_t;

endpackage : cid_pkg

// [rtl/cid_class_dec.sv]
// sub-class decoder for the jump-register and convert classes
`timescale 1ns/100ps
module cid_class_dec (
   input wire logic [2:0] i_sub,
   input wire logic i_convert,
   output cid_pkg::cid_op_t o_op,
   output logic o_reserved
);
   import cid_pkg::*;

   // ****************************************
   // sub-field tables
   // ****************************************
   // one table picked by class select
   always_comb begin
      o_op = OP_NONE;
      o_reserved = 1'b0;
      if (i_convert) begin
         // RQ10: convert class table
         case (i_sub)
            3'h0: o_op = OP_ZERO_EXTEND_BYTE;
            3'h1: o_op = OP_ZERO_EXTEND_HALF;
            3'h4: o_op = OP_SIGN_EXTEND_BYTE;
            3'h5: o_op = OP_SIGN_EXTEND_HALF;
            default: o_reserved = 1'b1;    // higher-level or reserved
         endcase
      end else begin
         // RQ9: jump register table
         case (i_sub)
            3'h0: o_op = OP_JUMP_REG;
            3'h1: o_op = OP_JUMP_REG_RA;
            3'h2: o_op = OP_JUMP_LINK_REG;
            3'h4: o_op = OP_COMPACT_JUMP_REG;
            3'h5: o_op = OP_COMPACT_JUMP_REG_RA;
            3'h6: o_op = OP_COMPACT_JUMP_LINK_REG;
            default: o_reserved = 1'b1;
         endcase
      end
   end

endmodule : cid_class_dec

// [rtl/cid_decoder.sv]
// registered decoder for the 16-bit compressed instruction set
`timescale 1ns/100ps
// What this block does
// RQ1: jump word bit 26 picks exchange variant
// RQ2: shift function: left, reserved, right, arithmetic
// RQ3: add format bit 4 zero adds immediate
// RQ4: imm8 group functions decoded from bits 10..8
// RQ5: three-register: 01 add, 11 subtract
// RQ6: two-register row 00 column table
// RQ7: rows 10 and 11 tables, others reserved
// RQ8: save/restore chosen by bit 7
// RQ9: jump register class from bits 7..5
// RQ10: convert class from bits 7..5
// RQ11: three add-immediate major opcodes mapped
// RQ12: stack and pc word access opcodes mapped
// RQ13: loads and stores are extensible
// RQ14: save and restore are extensible
// RQ15: immediate arithmetic is extensible
// RQ16: register arithmetic not extensible
// RQ17: breakpoints and extend not extensible
// RQ18: multiply, divide, hi/lo moves not extensible
// RQ19: listed branches are extensible
// RQ20: all jumps not extensible
// RQ21: immediate right shifts extensible, variable not
// RQ22: reserved encodings raise illegal
// RQ23: higher-level encodings raise illegal
// RQ24: major opcode from bits 15..11
// RQ25: one illegal flag beside operation
// RQ26: extend before non-extensible is illegal
module cid_decoder (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_valid,
   input wire logic [15:0] i_instr,
   output logic o_valid,
   output cid_pkg::cid_op_t o_op,
   output logic o_extensible,
   output logic o_extended,
   output logic o_illegal
);
   import cid_pkg::*;

   // ****************************************
   // field extraction
   // ****************************************
   logic [4:0] major;
   logic [2:0] i8_funct;
   logic [4:0] rr_funct;
   logic [1:0] f2;
   logic [2:0] sub;
   // prefix and jump word state
   logic ext_pending_r;
   logic ext_pending_nxt;
   logic ext_double_r;
   logic ext_double_nxt;
   logic jal_second_r;
   logic jal_exchange_r;
   cid_op_t op_nxt;
   logic resv_nxt;
   logic extn_nxt;
   cid_op_t class_op;
   logic class_resv;
   logic is_prefix;
   logic is_jal_first;
   // word that produces a result
   logic take_word;

   // RQ24: major opcode row and column
   assign major = i_instr[MAJOR_HI:MAJOR_LO];
   assign i8_funct = i_instr[I8_HI:I8_LO];
   assign rr_funct = i_instr[RR_HI:RR_LO];
   assign f2 = i_instr[F2_HI:F2_LO];
   assign sub = i_instr[SUB_HI:SUB_LO];
   // a word after a jump first half is jump data,
   // so its major field never opens a prefix
   assign is_prefix = (major == MJ_EXTEND) && !jal_second_r;
   assign is_jal_first = (major == MJ_JUMP_LINK) && !jal_second_r;

   // class decoder for jump-register and convert
   // both classes share the sub field, the function picks the table
   cid_class_dec u_class (
      .i_sub(sub),
      .i_convert(rr_funct == RR_CONVERT),
      .o_op(class_op),
      .o_reserved(class_resv)
   );

   // ****************************************
   // combinational decode
   // ****************************************
   // operation, reserved and extensible per word
   always_comb begin
      op_nxt = OP_NONE;
      resv_nxt = 1'b0;
      extn_nxt = 1'b0;
      if (jal_second_r) begin
         // RQ1: second half of jump word
         op_nxt = jal_exchange_r ? OP_JUMP_LINK_EXCHANGE : OP_JUMP_LINK;
      end else begin
         case (major)
            // RQ11: add immediate forms
            MJ_STACK_ADD: begin op_nxt = OP_STACK_ADD_IMM; extn_nxt = 1'b1; end
            MJ_PC_ADD: begin op_nxt = OP_PC_ADD_IMM; extn_nxt = 1'b1; end
            MJ_SHORT_ADD: begin op_nxt = OP_SHORT_ADD_IMM; extn_nxt = 1'b1; end
            // RQ19: extensible branches
            MJ_BRANCH: begin op_nxt = OP_BRANCH; extn_nxt = 1'b1; end
            MJ_BEQZ: begin op_nxt = OP_BEQZ; extn_nxt = 1'b1; end
            MJ_BNEZ: begin op_nxt = OP_BNEZ; extn_nxt = 1'b1; end
            // RQ20: jump word first half
            MJ_JUMP_LINK: op_nxt = OP_NONE;
            // RQ2: shift function field
            MJ_SHIFT: begin
               // RQ21: immediate shifts extensible
               extn_nxt = 1'b1;
               case (f2)
                  2'h0: op_nxt = OP_SLL;
                  2'h2: op_nxt = OP_SRL;
                  2'h3: op_nxt = OP_SRA;
                  default: begin resv_nxt = 1'b1; extn_nxt = 1'b0; end
               endcase
            end
            // RQ3: add format bit 4
            MJ_RRIA: begin
               if (!i_instr[RRIA_BIT]) begin
                  op_nxt = OP_ADD_IMM3;
                  extn_nxt = 1'b1;
               end else begin
                  resv_nxt = 1'b1;
               end
            end
            // RQ15: immediate arithmetic
            MJ_SLTI: begin op_nxt = OP_SLTI; extn_nxt = 1'b1; end
            MJ_SLTIU: begin op_nxt = OP_SLTIU; extn_nxt = 1'b1; end
            MJ_LI: begin op_nxt = OP_LI; extn_nxt = 1'b1; end
            MJ_CMPI: begin op_nxt = OP_CMPI; extn_nxt = 1'b1; end
            // RQ4: imm8 group functions
            MJ_IMM8: begin
               case (i8_funct)
                  3'h0: begin op_nxt = OP_BRANCH_T_ZERO; extn_nxt = 1'b1; end
                  3'h1: begin op_nxt = OP_BRANCH_T_NONZERO; extn_nxt = 1'b1; end
                  3'h2: begin op_nxt = OP_STORE_RETURN_ADDR_STACK; extn_nxt = 1'b1; end
                  3'h3: begin op_nxt = OP_ADJUST_STACK_PTR; extn_nxt = 1'b1; end
                  // RQ8: save or restore by bit 7
                  3'h4: begin
                     op_nxt = i_instr[SAVE_RESTORE_CLASS_BIT] ? OP_SAVE : OP_RESTORE;
                     // RQ14: save/restore extensible
                     extn_nxt = 1'b1;
                  end
                  3'h5: op_nxt = OP_MOVE_INTO_FULL_REG;
                  3'h7: op_nxt = OP_MOVE_FROM_FULL_REG;
                  default: resv_nxt = 1'b1;
               endcase
            end
            // RQ13: loads and stores extensible
            MJ_LB: begin op_nxt = OP_LB; extn_nxt = 1'b1; end
            MJ_LH: begin op_nxt = OP_LH; extn_nxt = 1'b1; end
            MJ_LW: begin op_nxt = OP_LW; extn_nxt = 1'b1; end
            MJ_LBU: begin op_nxt = OP_LBU; extn_nxt = 1'b1; end
            MJ_LHU: begin op_nxt = OP_LHU; extn_nxt = 1'b1; end
            MJ_SB: begin op_nxt = OP_SB; extn_nxt = 1'b1; end
            MJ_SH: begin op_nxt = OP_SH; extn_nxt = 1'b1; end
            MJ_SW: begin op_nxt = OP_SW; extn_nxt = 1'b1; end
            // RQ12: stack and pc word access
            MJ_STACK_LW: begin op_nxt = OP_STACK_LOAD_WORD; extn_nxt = 1'b1; end
            MJ_PC_LW: begin op_nxt = OP_PC_LOAD_WORD; extn_nxt = 1'b1; end
            MJ_STACK_SW: begin op_nxt = OP_STACK_STORE_WORD; extn_nxt = 1'b1; end
            // RQ5: three-register function
            MJ_THREE_REG: begin
               case (f2)
                  2'h1: op_nxt = OP_ADDU;
                  2'h3: op_nxt = OP_SUBU;
                  default: resv_nxt = 1'b1;
               endcase
            end
            // RQ16: register ops not extensible
            MJ_TWO_REG: begin
               // RQ6: two-register row and column
               case (rr_funct)
                  RR_JREG: begin op_nxt = class_op; resv_nxt = class_resv; end
                  5'h01: op_nxt = OP_DEBUG_BREAKPOINT;
                  5'h02: op_nxt = OP_SLT;
                  5'h03: op_nxt = OP_SLTU;
                  5'h04: op_nxt = OP_SLLV;
                  5'h05: op_nxt = OP_BREAK;
                  5'h06: op_nxt = OP_SRLV;
                  5'h07: op_nxt = OP_SRAV;
                  5'h0A: op_nxt = OP_CMP;
                  5'h0B: op_nxt = OP_NEG;
                  5'h0C: op_nxt = OP_AND;
                  5'h0D: op_nxt = OP_OR;
                  5'h0E: op_nxt = OP_XOR;
                  5'h0F: op_nxt = OP_NOT;
                  // RQ7: rows 10 and 11
                  5'h10: op_nxt = OP_MFHI;
                  RR_CONVERT: begin op_nxt = class_op; resv_nxt = class_resv; end
                  5'h12: op_nxt = OP_MFLO;
                  // RQ18: multiply and divide row
                  5'h18: op_nxt = OP_MULT;
                  5'h19: op_nxt = OP_MULTU;
                  5'h1A: op_nxt = OP_DIV;
                  5'h1B: op_nxt = OP_DIVU;
                  default: resv_nxt = 1'b1;
               endcase
            end
            // RQ17: prefix itself not extensible
            MJ_EXTEND: op_nxt = OP_EXTEND;
            // RQ23: higher-level column 7
            default: resv_nxt = 1'b1;
         endcase
      end
   end

   // ****************************************
   // prefix and jump word tracking
   // ****************************************
   // prefix waits for the word it widens; a jump first half is not
   // that word, so a pending prefix rides over it to the second half
   assign ext_pending_nxt = i_valid ? (is_prefix || (is_jal_first && ext_pending_r)) : ext_pending_r;

   // RQ17: prefix ahead of a prefix
   // remembered until the widened word can report it as illegal
   always_comb begin
      ext_double_nxt = ext_double_r;
      if (i_valid) begin
         if (is_prefix) begin
            ext_double_nxt = ext_double_r || ext_pending_r;
         end else if (!is_jal_first) begin
            ext_double_nxt = 1'b0;
         end
      end
   end

   // prefix state
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ext_pending_r <= 1'b0;
         ext_double_r <= 1'b0;
      end else begin
         ext_pending_r <= ext_pending_nxt;
         ext_double_r <= ext_double_nxt;
      end
   end

   // mode bit sits in the first half; the second half is offset only
   // RQ1: capture mode bit of first half
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         jal_second_r <= 1'b0;
         jal_exchange_r <= 1'b0;
      end else if (i_valid) begin
         jal_second_r <= is_jal_first;
         if (is_jal_first) begin
            jal_exchange_r <= i_instr[MODE_BIT];
         end
      end
   end

   // ****************************************
   // output registers
   // ****************************************
   // outputs other than o_valid move only when a result is made, so a prefix or a
   // jump first half leaves the last result standing
   assign take_word = i_valid && !is_prefix && !is_jal_first;

   // result strobe, one cycle per finished word
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_valid <= RST_VALID;
      end else begin
         o_valid <= take_word;
      end
   end

   // decoded operation holds until the next result
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_op <= OP_NONE;
      end else if (take_word) begin
         o_op <= op_nxt;
      end
   end

   // prefix flags held beside the operation
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_extensible <= 1'b0;
         o_extended <= 1'b0;
      end else if (take_word) begin
         o_extensible <= extn_nxt;
         o_extended <= ext_pending_r;
      end
   end

   // RQ22: reserved encodings illegal
   // RQ25: single illegal indication
   // RQ26: prefix on non-extensible word
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_illegal <= 1'b0;
      end else if (take_word) begin
         o_illegal <= resv_nxt || (ext_pending_r && !extn_nxt) || ext_double_r;
      end
   end

endmodule : cid_decoder

// [verification/cid_decoder_props.sv]
// assertion checker for the compressed instruction decoder ports
`timescale 1ns/100ps
module cid_decoder_props
   import cid_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_valid,
   input wire logic [15:0] i_instr,
   input wire logic o_valid,
   input wire cid_pkg::cid_op_t o_op,
   input wire logic o_extensible,
   input wire logic o_extended,
   input wire logic o_illegal
);
   logic jl_r;
   logic jx_r;
   logic [4:0] mj;
   logic take;
   assign mj = i_instr[15:11];
   assign take = i_valid && !jl_r;
   // tracks the first half of a two-word jump
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         jl_r <= 1'b0;
         jx_r <= 1'b0;
      end else if (i_valid) begin
         jl_r <= !jl_r && (mj == MJ_JUMP_LINK);
         jx_r <= jl_r ? jx_r : i_instr[MODE_BIT];
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   property p_answer; take && mj != MJ_EXTEND && mj != MJ_JUMP_LINK |=> o_valid; endproperty
   a_answer: assert property (p_answer) else $error("word gave no result");
   property p_prefix_quiet; take && mj == MJ_EXTEND |=> !o_valid; endproperty
   a_prefix_quiet: assert property (p_prefix_quiet) else $error("prefix gave a result");
   property p_jl_exch;
      i_valid && jl_r |=> o_valid && !o_extensible && o_op == (jx_r ? OP_JUMP_LINK_EXCHANGE : OP_JUMP_LINK);
   endproperty
   a_jl_exch: assert property (p_jl_exch) else $error("jump variant wrong");
   property p_shift_sra; take && mj == MJ_SHIFT && i_instr[1:0] == 2'h3 |=> o_op == OP_SRA && o_extensible; endproperty
   a_shift_sra: assert property (p_shift_sra) else $error("shift code wrong");
   property p_rrr_add; take && mj == MJ_THREE_REG && i_instr[1:0] == 2'h1 |=> o_op == OP_ADDU && !o_extensible;
   endproperty
   a_rrr_add: assert property (p_rrr_add) else $error("three-register add wrong");
   property p_save_restore_class;
      take && mj == MJ_IMM8 && i_instr[10:8] == 3'h4 |=> o_op == ($past(i_instr[SAVE_RESTORE_CLASS_BIT]) ? OP_SAVE : OP_RESTORE);
   endproperty
   a_save_restore_class: assert property (p_save_restore_class) else $error("save/restore pick wrong");
   property p_ext_illegal; o_valid && o_extended && !o_extensible |-> o_illegal; endproperty
   a_ext_illegal: assert property (p_ext_illegal) else $error("bad prefix not flagged");
   property p_resv_none; o_valid && o_illegal && !o_extended |-> o_op == OP_NONE && !o_extensible; endproperty
   a_resv_none: assert property (p_resv_none) else $error("reserved word decoded");
   property p_hold; !o_valid |-> $stable(o_op) && $stable(o_illegal) && $stable(o_extended); endproperty
   a_hold: assert property (p_hold) else $error("result moved without word");
   c_prefix_used: cover property (o_valid && o_extended && !o_illegal);
   c_jl_exch: cover property (o_valid && o_op == OP_JUMP_LINK_EXCHANGE);
   c_prefix_jl: cover property (o_valid && o_extended && o_op == OP_JUMP_LINK);
endmodule : cid_decoder_props
bind cid_decoder cid_decoder_props chk_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_valid(i_valid),
   .i_instr(i_instr), .o_valid(o_valid), .o_op(o_op), .o_extensible(o_extensible), .o_extended(o_extended),
   .o_illegal(o_illegal));

// [verification/cid_fetch_model.sv]
// fetch-stage model that offers 16-bit words to the decoder
`timescale 1ns/100ps
module cid_fetch_model (
   input wire logic i_sys_clk,
   output logic o_valid,
   output logic [15:0] o_instr
);
   initial begin
      o_valid = 1'b0;
      o_instr = 16'hA5C3;
   end
   // offer one word after idle cycles; word lines scramble while idle
   task automatic put(input logic [15:0] w, input int gap);
      repeat (gap) begin
         @(negedge i_sys_clk);
         o_valid = 1'b0;
         o_instr = ~o_instr;
      end
      @(negedge i_sys_clk);
      o_valid = 1'b1;
      o_instr = w;
   endtask : put
   task automatic idle();
      @(negedge i_sys_clk);
      o_valid = 1'b0;
      o_instr = ~o_instr;
   endtask : idle
endmodule : cid_fetch_model

// [verification/tb_cid_decoder.sv]
// self-checking bench for the compressed instruction decoder
`timescale 1ns/100ps
module tb_cid_decoder;
   import cid_pkg::*;
   logic i_sys_clk;
   logic i_rstn;
   logic i_valid;
   logic [15:0] i_instr;
   logic o_valid;
   cid_op_t o_op;
   logic o_extensible;
   logic o_extended;
   logic o_illegal;
   int mismatches;
   int total_checks;
   logic [9:0] exp_q[$];
   logic [10:0] exp_w;
   bit pend_ext;
   bit pend_jl;
   bit jl_x;
   bit pend_dbl;
   cid_op_t mj_tab[32] = '{OP_STACK_ADD_IMM, OP_PC_ADD_IMM, OP_BRANCH, OP_NONE, OP_BEQZ, OP_BNEZ, OP_NONE,
      OP_NONE, OP_NONE, OP_SHORT_ADD_IMM, OP_SLTI, OP_SLTIU, OP_NONE, OP_LI, OP_CMPI, OP_NONE, OP_LB, OP_LH,
      OP_STACK_LOAD_WORD, OP_LW, OP_LBU, OP_LHU, OP_PC_LOAD_WORD, OP_NONE, OP_SB, OP_SH, OP_STACK_STORE_WORD,
      OP_SW, OP_NONE, OP_NONE, OP_NONE, OP_NONE};
   cid_op_t rr_tab[32] = '{OP_NONE, OP_DEBUG_BREAKPOINT, OP_SLT, OP_SLTU, OP_SLLV, OP_BREAK, OP_SRLV, OP_SRAV,
      OP_NONE, OP_NONE, OP_CMP, OP_NEG, OP_AND, OP_OR, OP_XOR, OP_NOT, OP_MFHI, OP_NONE, OP_MFLO, OP_NONE,
      OP_NONE, OP_NONE, OP_NONE, OP_NONE, OP_MULT, OP_MULTU, OP_DIV, OP_DIVU, OP_NONE, OP_NONE, OP_NONE, OP_NONE};
   cid_op_t jr_tab[8] = '{OP_JUMP_REG, OP_JUMP_REG_RA, OP_JUMP_LINK_REG, OP_NONE, OP_COMPACT_JUMP_REG,
      OP_COMPACT_JUMP_REG_RA, OP_COMPACT_JUMP_LINK_REG, OP_NONE};
   cid_op_t cv_tab[8] = '{OP_ZERO_EXTEND_BYTE, OP_ZERO_EXTEND_HALF, OP_NONE, OP_NONE, OP_SIGN_EXTEND_BYTE,
      OP_SIGN_EXTEND_HALF, OP_NONE, OP_NONE};
   cid_op_t i8_tab[8] = '{OP_BRANCH_T_ZERO, OP_BRANCH_T_NONZERO, OP_STORE_RETURN_ADDR_STACK,
      OP_ADJUST_STACK_PTR, OP_NONE, OP_MOVE_INTO_FULL_REG, OP_NONE, OP_MOVE_FROM_FULL_REG};
   cid_op_t sh_tab[4] = '{OP_SLL, OP_NONE, OP_SRL, OP_SRA};
   cid_op_t rrr_tab[4] = '{OP_NONE, OP_ADDU, OP_NONE, OP_SUBU};

   cid_decoder dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_valid(i_valid), .i_instr(i_instr),
      .o_valid(o_valid), .o_op(o_op), .o_extensible(o_extensible), .o_extended(o_extended), .o_illegal(o_illegal));
   cid_fetch_model fetch_u (.i_sys_clk(i_sys_clk), .o_valid(i_valid), .o_instr(i_instr));

   // reference decode of one ordinary word
   function automatic void ref_dec(input logic [15:0] w, output cid_op_t op, output logic ex);
      op = mj_tab[w[15:11]];
      ex = 1'b1;
      case (w[15:11])
         MJ_SHIFT: op = sh_tab[w[1:0]];
         MJ_RRIA: op = w[RRIA_BIT] ? OP_NONE : OP_ADD_IMM3;
         MJ_IMM8: begin
            op = i8_tab[w[10:8]];
            if (w[10:8] == 3'h4) begin
               op = w[SAVE_RESTORE_CLASS_BIT] ? OP_SAVE : OP_RESTORE;
            end
            ex = (w[10:8] != 3'h5) && (w[10:8] != 3'h7);
         end
         MJ_THREE_REG: begin
            op = rrr_tab[w[1:0]];
            ex = 1'b0;
         end
         MJ_TWO_REG: begin
            op = (w[4:0] == RR_JREG) ? jr_tab[w[7:5]] : ((w[4:0] == RR_CONVERT) ? cv_tab[w[7:5]] : rr_tab[w[4:0]]);
            ex = 1'b0;
         end
         default: ;
      endcase
      if (op == OP_NONE) begin
         ex = 1'b0;
      end
   endfunction : ref_dec

   task automatic check(input logic [10:0] seen, input logic [10:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // model the prefix and two-word jump, then hand the word to the fetch model
   task automatic send(input logic [15:0] w, input int gap);
      cid_op_t op;
      logic ex;
      if (pend_jl) begin
         op = jl_x ? OP_JUMP_LINK_EXCHANGE : OP_JUMP_LINK;
         exp_q.push_back({op, 1'b0, pend_ext, pend_ext});
         pend_jl = 1'b0;
         pend_ext = 1'b0;
         pend_dbl = 1'b0;
      end else if (w[15:11] == MJ_EXTEND) begin
         pend_dbl = pend_dbl || pend_ext;
         pend_ext = 1'b1;
      end else if (w[15:11] == MJ_JUMP_LINK) begin
         pend_jl = 1'b1;
         jl_x = w[MODE_BIT];
      end else begin
         ref_dec(w, op, ex);
         exp_q.push_back({op, ex, pend_ext, (op == OP_NONE) || (pend_ext && !ex) || pend_dbl});
         pend_ext = 1'b0;
         pend_dbl = 1'b0;
      end
      fetch_u.put(w, gap);
   endtask : send

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   // compare every result and every stray result with the model
   always @(negedge i_sys_clk) begin
      if (i_rstn === 1'b1 && o_valid !== 1'b0) begin
         exp_w = (exp_q.size() > 0) ? {1'b1, exp_q.pop_front()} : 11'h000;
         check({o_valid, o_op, o_extensible, o_extended, o_illegal}, exp_w);
      end
   end

   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   initial begin
      logic [15:0] w;
      int n;
      mismatches = 0;
      total_checks = 0;
      i_rstn = 1'b0;
      void'($urandom(32'h7a1c));
      repeat (6) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check({o_valid, o_op, o_extensible, o_extended, o_illegal}, 11'h000);
      i_rstn = 1'b1;
      // every non-prefix word back to back
      for (n = 0; n < 65536; n++) begin
         if (n[15:11] != MJ_EXTEND) begin
            send(16'(n), 0);
         end
      end
      // random words, prefixes often and doubled, gaps of zero to two cycles
      for (n = 0; n < 3000; n++) begin
         w = 16'($urandom());
         if ($urandom_range(3) == 0) begin
            w[15:11] = MJ_EXTEND;
         end
         send(w, $urandom_range(2));
      end
      fetch_u.idle();
      n = 0;
      while (exp_q.size() > 0 && n < 20) begin
         @(negedge i_sys_clk);
         n++;
      end
      check(11'(exp_q.size()), 11'h000);
      finish_test();
   end
endmodule : tb_cid_decoder
